//--- core/iuvfm_pkg.sv
/*
 * Constants, register map and state encoding for the input undervoltage
 * fault manager. Assumes a 125 MHz core clock and telemetry in volts with
 * eight fraction bits.
 */
// How it works
// - warning crossing sets summary, warning bit, alert
// - fault crossing sets summary, fault bit, alert
// - retry waits for input at or above warning threshold
// - thresholds are exponent/mantissa, mantissa times two^exp
// - out-of-range threshold writes rejected, old kept
// - warning threshold resets to cb80 (7.0 V)
// - fault threshold resets to cb40 (6.5 V)
// - fault pulls alert low, bit held until clear
// - action code 10 means disable then retry
// - retry field zero keeps output off until clear or an off command
// - nonzero retry field retries until commanded off or stopped by another fault
// - retry spacing is (delay+1) times 35 ms
// - action byte resets to 80 (disable, no retry)
package iuvfm_pkg;
   // command codes
   localparam logic [7:0] IUVFM_ADDR_WARN = 8'h58;
   localparam logic [7:0] IUVFM_ADDR_FAULT = 8'h59;
   localparam logic [7:0] IUVFM_ADDR_ACTION = 8'h5a;
   // reset values
   localparam logic [15:0] IUVFM_WARN_RST = 16'hcb80;
   localparam logic [15:0] IUVFM_FAULT_RST = 16'hcb40;
   localparam logic [7:0] IUVFM_ACTION_RST = 8'h80;
   // same thresholds in volts with eight fraction bits
   localparam logic [15:0] IUVFM_WARN_FIX_RST = 16'h0700;
   localparam logic [15:0] IUVFM_FAULT_FIX_RST = 16'h0680;
   localparam int IUVFM_FRAC_BITS = 8;
   localparam logic [15:0] IUVFM_MAX_FIX = 16'h1000;
   // threshold field layout
   localparam int IUVFM_EXP_MSB = 15;
   localparam int IUVFM_EXP_LSB = 11;
   localparam int IUVFM_MANT_MSB = 10;
   // action byte layout
   localparam int IUVFM_MODE_MSB = 7;
   localparam int IUVFM_MODE_LSB = 6;
   localparam logic [1:0] IUVFM_MODE_RETRY = 2'h2;
   localparam int IUVFM_RETRY_MSB = 5;
   localparam int IUVFM_RETRY_LSB = 3;
   localparam int IUVFM_DLY_MSB = 2;
   // retry timing
   localparam int IUVFM_RETRY_UNIT_MS = 35;
   localparam int IUVFM_CLK_KHZ = 125000;
   localparam int IUVFM_RETRY_UNIT_CYC = IUVFM_RETRY_UNIT_MS * IUVFM_CLK_KHZ;
   // output control states
   typedef enum logic [1:0] {
      IUVFM_ST_OFF = 2'b00,
      IUVFM_ST_ON = 2'b01,
      IUVFM_ST_WAIT = 2'b10,
      IUVFM_ST_LATCH = 2'b11
   } iuvfm_state_t;
endpackage

//--- core/iuvfm_l11_if.sv
/*
 * Carrier between the fault manager and its threshold converter.
 * Assumes both ends on the same clock; the path is combinational.
 */
`timescale 1ns/1ns
interface iuvfm_l11_if;
   logic [15:0] raw;
   logic [15:0] fixed;
   logic ok;
   modport conv (input raw, output fixed, output ok);
   modport user (output raw, input fixed, input ok);
endinterface

//--- core/iuvfm_l11_conv.sv
/*
 * Converts an exponent/mantissa threshold to volts with eight fraction
 * bits and flags whether it lies in 0 V to 16 V. Purely combinational.
 */
`timescale 1ns/1ns
module iuvfm_l11_conv import iuvfm_pkg::*; (
   // conversion carrier
   iuvfm_l11_if.conv cv
);
   logic signed [5:0] sh;
   logic [39:0] mag;
   logic [39:0] res;
   logic neg;

   ////////////////////////////////////////////////////////////////////
   // value = mantissa * 2^exponent, rescaled by the fraction bits
   always_comb begin
      neg = cv.raw[IUVFM_MANT_MSB];
      sh = 6'(signed'(cv.raw[IUVFM_EXP_MSB:IUVFM_EXP_LSB])) + 6'(IUVFM_FRAC_BITS);
      mag = {29'h0, cv.raw[IUVFM_MANT_MSB:0]};
      if (sh < 0) begin
         res = mag >> 6'(-sh); // fraction below resolution is dropped
      end else begin
         res = mag << sh;
      end
      // negative mantissa is below 0 V, never accepted
      cv.ok = !neg && (res <= 40'(IUVFM_MAX_FIX));
      cv.fixed = res[15:0];
   end
endmodule

//--- core/iuvfm_top.sv
/*
 * Input undervoltage fault manager: threshold and action registers on a
 * command port, sample comparison, status latching, alert and retry.
 * Assumes the command decoder and telemetry run on clk; the enable pin
 * arrives asynchronously and is synchronised here.
 */
`timescale 1ns/1ns
module iuvfm_top import iuvfm_pkg::*; #(
   parameter int RETRY_UNIT_CYC = IUVFM_RETRY_UNIT_CYC
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // command port from the management bus engine
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata,
   input wire logic clear_faults,
   output logic [15:0] cmd_rdata_ff,
   output logic cmd_nack_ff,
   // telemetry
   input wire logic vin_valid,
   input wire logic [15:0] vin_sample,
   // on/off control
   input wire logic enable_pin,
   input wire logic operation_on,
   input wire logic other_fault_stop,
   // status and outputs
   output logic sts_none_above_ff,
   output logic sts_input_ff,
   output logic sts_uv_warn_ff,
   output logic sts_uv_fault_ff,
   output logic host_alert_output_n_ff,
   output logic output_en_ff
);
   logic [1:0] rst_sync_ff;
   logic rstn;
   logic [1:0] en_sync_ff;
   logic [15:0] warn_ff, nxt_warn, fault_ff, nxt_fault;
   logic [15:0] warn_fix_ff, nxt_warn_fix, fault_fix_ff, nxt_fault_fix;
   logic [7:0] action_ff, nxt_action;
   logic [15:0] nxt_rdata;
   logic nxt_nack;
   logic below_warn_ff, nxt_below_warn, below_fault_ff, nxt_below_fault;
   logic nxt_none_above, nxt_input, nxt_uv_warn, nxt_uv_fault;
   logic warn_evt, fault_evt, on_req;
   iuvfm_state_t st_ff, nxt_st;
   logic retry_ff, nxt_retry;
   logic [31:0] dly_cnt_ff, nxt_dly_cnt, dly_target;
   iuvfm_l11_if cvif ();

   ////////////////////////////////////////////////////////////////////
   // reset release and enable pin synchronisers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_ff <= 2'b00;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rstn = rst_sync_ff[1];

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         en_sync_ff <= 2'b00;
      end else if (ce) begin
         en_sync_ff <= {en_sync_ff[0], enable_pin};
      end
   end
   assign on_req = en_sync_ff[1] && operation_on;

   iuvfm_l11_conv u_conv (
      .cv(cvif.conv)
   );
   assign cvif.raw = cmd_wdata;

   ////////////////////////////////////////////////////////////////////
   // register writes and reads; a rejected threshold keeps its old value
   always_comb begin
      nxt_warn = warn_ff;
      nxt_fault = fault_ff;
      nxt_warn_fix = warn_fix_ff;
      nxt_fault_fix = fault_fix_ff;
      nxt_action = action_ff;
      nxt_rdata = cmd_rdata_ff;
      nxt_nack = 1'b0;
      if (cmd_wr) begin
         case (cmd_code)
            IUVFM_ADDR_WARN: begin
               if (cvif.ok) begin
                  nxt_warn = cmd_wdata;
                  nxt_warn_fix = cvif.fixed;
               end else begin
                  nxt_nack = 1'b1;
               end
            end
            IUVFM_ADDR_FAULT: begin
               if (cvif.ok) begin
                  nxt_fault = cmd_wdata;
                  nxt_fault_fix = cvif.fixed;
               end else begin
                  nxt_nack = 1'b1;
               end
            end
            IUVFM_ADDR_ACTION: nxt_action = cmd_wdata[7:0];
            default: nxt_nack = 1'b1;
         endcase
      end else if (cmd_rd) begin
         case (cmd_code)
            IUVFM_ADDR_WARN: nxt_rdata = warn_ff;
            IUVFM_ADDR_FAULT: nxt_rdata = fault_ff;
            IUVFM_ADDR_ACTION: nxt_rdata = {8'h00, action_ff};
            default: begin
               nxt_rdata = 16'h0000;
               nxt_nack = 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sample comparison: events fire only on the crossing itself
   always_comb begin
      nxt_below_warn = below_warn_ff;
      nxt_below_fault = below_fault_ff;
      if (vin_valid) begin
         nxt_below_warn = vin_sample < warn_fix_ff;
         nxt_below_fault = vin_sample < fault_fix_ff;
      end
      warn_evt = nxt_below_warn && !below_warn_ff;
      fault_evt = nxt_below_fault && !below_fault_ff;
   end

   // sticky status; a new event beats a clear in the same cycle
   always_comb begin
      nxt_uv_warn = (sts_uv_warn_ff && !clear_faults) || warn_evt;
      nxt_uv_fault = (sts_uv_fault_ff && !clear_faults) || fault_evt;
      nxt_none_above = (sts_none_above_ff && !clear_faults) || warn_evt || fault_evt;
      nxt_input = (sts_input_ff && !clear_faults) || warn_evt || fault_evt;
   end

   ////////////////////////////////////////////////////////////////////
   // output control: latch off or retry after the programmed spacing
   always_comb begin
      dly_target = 32'(action_ff[IUVFM_DLY_MSB:0] + 4'h1) * 32'(RETRY_UNIT_CYC);
      nxt_st = st_ff;
      nxt_retry = retry_ff;
      nxt_dly_cnt = (dly_cnt_ff < dly_target) ? dly_cnt_ff + 32'h0000_0001 : dly_cnt_ff;
      case (st_ff)
         IUVFM_ST_OFF: begin
            nxt_retry = 1'b0;
            if (on_req && !other_fault_stop) begin
               nxt_st = IUVFM_ST_ON;
            end
         end
         IUVFM_ST_ON: begin
            if (!on_req || other_fault_stop) begin
               nxt_st = IUVFM_ST_OFF;
            end else if (fault_evt) begin
               // unused mode codes fall back to a plain latch-off
               if (action_ff[IUVFM_MODE_MSB:IUVFM_MODE_LSB] == IUVFM_MODE_RETRY &&
                   action_ff[IUVFM_RETRY_MSB:IUVFM_RETRY_LSB] != 3'h0) begin
                  nxt_st = IUVFM_ST_WAIT;
                  if (!retry_ff) begin
                     nxt_dly_cnt = 32'h0000_0000;
                  end
               end else begin
                  nxt_st = IUVFM_ST_LATCH;
               end
            end
         end
         IUVFM_ST_WAIT: begin
            if (!on_req || other_fault_stop) begin
               nxt_st = IUVFM_ST_OFF;
            end else if (dly_cnt_ff >= dly_target && !below_warn_ff) begin
               nxt_st = IUVFM_ST_ON;
               nxt_retry = 1'b1;
               nxt_dly_cnt = 32'h0000_0000;
            end
         end
         IUVFM_ST_LATCH: begin
            if (clear_faults || !on_req) begin
               nxt_st = IUVFM_ST_OFF;
            end
         end
         default: nxt_st = IUVFM_ST_OFF;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // all state registers but the synchronisers; ce low freezes everything except the reset synchroniser
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         warn_ff <= IUVFM_WARN_RST;
         fault_ff <= IUVFM_FAULT_RST;
         warn_fix_ff <= IUVFM_WARN_FIX_RST;
         fault_fix_ff <= IUVFM_FAULT_FIX_RST;
         action_ff <= IUVFM_ACTION_RST;
         cmd_rdata_ff <= 16'h0000;
         cmd_nack_ff <= 1'b0;
         below_warn_ff <= 1'b0;
         below_fault_ff <= 1'b0;
         sts_uv_warn_ff <= 1'b0;
         sts_uv_fault_ff <= 1'b0;
         sts_none_above_ff <= 1'b0;
         sts_input_ff <= 1'b0;
         host_alert_output_n_ff <= 1'b1;
         st_ff <= IUVFM_ST_OFF;
         retry_ff <= 1'b0;
         dly_cnt_ff <= 32'h0000_0000;
         output_en_ff <= 1'b0;
      end else if (ce) begin
         warn_ff <= nxt_warn;
         fault_ff <= nxt_fault;
         warn_fix_ff <= nxt_warn_fix;
         fault_fix_ff <= nxt_fault_fix;
         action_ff <= nxt_action;
         cmd_rdata_ff <= nxt_rdata;
         cmd_nack_ff <= nxt_nack;
         below_warn_ff <= nxt_below_warn;
         below_fault_ff <= nxt_below_fault;
         sts_uv_warn_ff <= nxt_uv_warn;
         sts_uv_fault_ff <= nxt_uv_fault;
         sts_none_above_ff <= nxt_none_above;
         sts_input_ff <= nxt_input;
         host_alert_output_n_ff <= !(nxt_uv_warn || nxt_uv_fault);
         st_ff <= nxt_st;
         retry_ff <= nxt_retry;
         dly_cnt_ff <= nxt_dly_cnt;
         output_en_ff <= (nxt_st == IUVFM_ST_ON);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_warn_set;
      ce && warn_evt |=> sts_uv_warn_ff && sts_input_ff && sts_none_above_ff;
   endproperty
   a_warn_set: assert property (p_warn_set) else $error("warning bit not set");

   property p_fault_set;
      ce && fault_evt |=> sts_uv_fault_ff && sts_input_ff && sts_none_above_ff;
   endproperty
   a_fault_set: assert property (p_fault_set) else $error("fault bit not set");

   property p_no_early_retry;
      ce && st_ff == IUVFM_ST_WAIT && below_warn_ff |=> !output_en_ff;
   endproperty
   a_no_early_retry: assert property (p_no_early_retry) else $error("retry below warn");

   property p_reject_keeps;
      ce && cmd_wr && cmd_code == IUVFM_ADDR_WARN && !cvif.ok |=> $stable(warn_ff) && cmd_nack_ff;
   endproperty
   a_reject_keeps: assert property (p_reject_keeps) else $error("bad write stored");

   property p_alert_low;
      ce && fault_evt |=> !host_alert_output_n_ff ##1 (sts_uv_fault_ff || $past(clear_faults));
   endproperty
   a_alert_low: assert property (p_alert_low) else $error("alert not raised");

   property p_mode_latch;
      ce && st_ff == IUVFM_ST_ON && fault_evt && on_req && !other_fault_stop &&
      action_ff[IUVFM_RETRY_MSB:IUVFM_RETRY_LSB] == 3'h0 |=> st_ff == IUVFM_ST_LATCH;
   endproperty
   a_mode_latch: assert property (p_mode_latch) else $error("no latch-off");

   property p_latch_off;
      st_ff == IUVFM_ST_LATCH |-> !output_en_ff;
   endproperty
   a_latch_off: assert property (p_latch_off) else $error("output on while latched");

   property p_stop_retry;
      ce && st_ff == IUVFM_ST_WAIT && !on_req |=> st_ff == IUVFM_ST_OFF && !output_en_ff;
   endproperty
   a_stop_retry: assert property (p_stop_retry) else $error("retry not stopped");

   property p_spacing;
      ce && st_ff == IUVFM_ST_WAIT && nxt_st == IUVFM_ST_ON |-> dly_cnt_ff >= dly_target;
   endproperty
   a_spacing: assert property (p_spacing) else $error("retry too early");

   property p_once_per_cross;
      ce && warn_evt |=> !warn_evt;
   endproperty
   a_once_per_cross: assert property (p_once_per_cross) else $error("double warn event");
endmodule

//--- verification/iuvfm_host_model.sv
/*
 * Management bus host model: issues command-port writes, reads and
 * clear-faults pulses to the fault manager.
 * Assumes the same clk as the device; calls start just after an edge.
 */
`timescale 1ns/1ns
module iuvfm_host_model (
   // clock
   input wire logic clk,
   // command port
   output logic cmd_wr,
   output logic cmd_rd,
   output logic [7:0] cmd_code,
   output logic [15:0] cmd_wdata,
   output logic clear_faults
);
   ////////////////////////////////////////////////////////////////////////
   // idle bus at time zero
   initial begin
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
      clear_faults = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // one strobe cycle; released lines show inverted data, no bus keeper
   task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] data);
      cmd_wr <= wr;
      cmd_rd <= ~wr;
      cmd_code <= code;
      cmd_wdata <= data;
      @(posedge clk);
      cmd_wr <= 1'b0;
      cmd_rd <= 1'b0;
      cmd_code <= ~code;
      cmd_wdata <= ~data;
      @(posedge clk);
   endtask
   // clear-faults pulse, gap cycle so pulses never merge
   task automatic clear();
      clear_faults <= 1'b1;
      @(posedge clk);
      clear_faults <= 1'b0;
      @(posedge clk);
   endtask
endmodule

//--- verification/iuvfm_tb_top.sv
/*
 * Self-checking bench for the input undervoltage fault manager.
 * Assumes the host model drives the command port and the retry unit is
 * shortened to ten cycles.
 */
`timescale 1ns/1ns
module iuvfm_tb_top;
   import iuvfm_pkg::*;
   localparam int UNIT = 10;
   logic clk, resetn, enable_pin, operation_on, other_fault_stop, vin_valid, ce;
   logic cmd_wr, cmd_rd, clear_faults, cmd_nack_ff, host_alert_output_n_ff, output_en_ff;
   logic sts_none_above_ff, sts_input_ff, sts_uv_warn_ff, sts_uv_fault_ff;
   logic [7:0] cmd_code;
   logic [15:0] cmd_wdata, cmd_rdata_ff, vin_sample;
   logic [17:0] exp_q[$];
   logic [17:0] ent;
   logic tk1 = 1'b0;
   int n_mismatch = 0;
   int comparisons = 0;
   int cycles = 0;
   int seed = 22;
   ////////////////////////////////////////////////////////////////////////
   // device and host
   iuvfm_top #(.RETRY_UNIT_CYC(UNIT)) u_dut (.clk(clk), .resetn(resetn), .ce(ce),
      .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
      .clear_faults(clear_faults), .cmd_rdata_ff(cmd_rdata_ff), .cmd_nack_ff(cmd_nack_ff),
      .vin_valid(vin_valid), .vin_sample(vin_sample), .enable_pin(enable_pin),
      .operation_on(operation_on), .other_fault_stop(other_fault_stop),
      .sts_none_above_ff(sts_none_above_ff), .sts_input_ff(sts_input_ff),
      .sts_uv_warn_ff(sts_uv_warn_ff), .sts_uv_fault_ff(sts_uv_fault_ff),
      .host_alert_output_n_ff(host_alert_output_n_ff), .output_en_ff(output_en_ff));
   iuvfm_host_model u_host (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .clear_faults(clear_faults));
   ////////////////////////////////////////////////////////////////////////
   // verdict and comparison
   task automatic tally_and_finish();
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // drivers: each access notes its expected answer first
   task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic nk);
      exp_q.push_back({1'b0, nk, 16'h0000});
      u_host.access(1'b1, c, d);
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] d, input logic nk);
      exp_q.push_back({1'b1, nk, d});
      u_host.access(1'b0, c, 16'h0000);
   endtask
   task automatic feed(input logic [15:0] v);
      vin_valid <= 1'b1;
      vin_sample <= v;
      @(posedge clk);
      vin_valid <= 1'b0;
      @(posedge clk);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // random sample at or above the 7 V warning level, below 16 V
   function automatic logic [15:0] rnd_hi();
      return 16'h0700 + 16'({$random(seed)} % 32'h0900);
   endfunction
   // status and output, checked mid-cycle where everything has settled
   task automatic sts(input logic w, input logic f, input logic oe);
      @(negedge clk);
      check("uv_warn", {15'h0, w}, {15'h0, sts_uv_warn_ff});
      check("uv_fault", {15'h0, f}, {15'h0, sts_uv_fault_ff});
      check("summary", {14'h0, w | f, w | f}, {14'h0, sts_input_ff, sts_none_above_ff});
      check("alert_n", {15'h0, ~(w | f)}, {15'h0, host_alert_output_n_ff});
      check("output_en", {15'h0, oe}, {15'h0, output_en_ff});
      @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // clock, timeout, answer monitor; nack stands only in the cycle after taking
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      tk1 <= cmd_wr | cmd_rd;
      if (cycles == 3000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   always @(negedge clk) begin
      if (tk1 === 1'b1 && exp_q.size() > 0) begin
         ent = exp_q.pop_front();
         if (ent[17]) check("rdata", ent[15:0], cmd_rdata_ff);
         check("nack", {15'h0, ent[16]}, {15'h0, cmd_nack_ff});
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      resetn = 1'b0;
      ce = 1'b1;
      enable_pin = 1'b0;
      operation_on = 1'b0;
      other_fault_stop = 1'b0;
      vin_valid = 1'b0;
      vin_sample = 16'h0800;
      idle(2);
      resetn <= 1'b1;
      idle(4);
      rd(IUVFM_ADDR_WARN, 16'hcb80, 1'b0);
      rd(IUVFM_ADDR_FAULT, 16'hcb40, 1'b0);
      rd(IUVFM_ADDR_ACTION, 16'h0080, 1'b0);
      rd(8'h5b, 16'h0000, 1'b1);
      wr(IUVFM_ADDR_FAULT, 16'h0bc0, 1'b1);
      wr(IUVFM_ADDR_FAULT, 16'h0011, 1'b1);
      wr(IUVFM_ADDR_WARN, 16'hcfc0, 1'b1);
      rd(IUVFM_ADDR_FAULT, 16'hcb40, 1'b0);
      wr(IUVFM_ADDR_WARN, 16'h0007, 1'b0);
      rd(IUVFM_ADDR_WARN, 16'h0007, 1'b0);
      enable_pin <= 1'b1;
      operation_on <= 1'b1;
      idle(8);
      feed(16'h0700);
      sts(0, 0, 1);
      feed(16'h06ff);
      sts(1, 0, 1);
      u_host.clear();
      sts(0, 0, 1);
      feed(16'h06e0);
      sts(0, 0, 1);
      // every response mode, delay field zero
      for (int m = 0; m < 5; m++) begin
         if (m < 4) wr(IUVFM_ADDR_ACTION, {8'h00, m[1:0], 6'b001000}, 1'b0);
         else wr(IUVFM_ADDR_ACTION, 16'h0080, 1'b0);
         feed(rnd_hi());
         feed(16'h0500);
         sts(1, 1, 0);
         feed(rnd_hi());
         idle(30);
         sts(1, 1, m == 2);
         u_host.clear();
         idle(4);
         sts(0, 0, 1);
      end
      // four-unit wait (delay field 3) held off by low input, then spacing from attempt start
      wr(IUVFM_ADDR_ACTION, 16'h008b, 1'b0);
      feed(16'h0500);
      feed(16'h06ff);
      idle(60);
      sts(1, 1, 0);
      feed(rnd_hi());
      idle(3);
      sts(1, 1, 1);
      feed(16'h0500);
      feed(rnd_hi());
      idle(28);
      sts(1, 1, 0);
      idle(8);
      sts(1, 1, 1);
      // off command ends the retries
      feed(16'h0500);
      feed(rnd_hi());
      operation_on <= 1'b0;
      idle(60);
      sts(1, 1, 0);
      operation_on <= 1'b1;
      idle(6);
      sts(1, 1, 1);
      // another fault during the retry wait also ends the retries
      feed(16'h0500);
      feed(rnd_hi());
      other_fault_stop <= 1'b1;
      idle(60);
      sts(1, 1, 0);
      other_fault_stop <= 1'b0;
      idle(4);
      sts(1, 1, 1);
      // frozen clock enable must ignore a fault sample
      ce <= 1'b0;
      feed(16'h0500);
      sts(1, 1, 1);
      ce <= 1'b1;
      // mid-run reset restores defaults and clears status
      resetn <= 1'b0;
      idle(2);
      sts(0, 0, 0);
      resetn <= 1'b1;
      idle(4);
      rd(IUVFM_ADDR_WARN, 16'hcb80, 1'b0);
      rd(IUVFM_ADDR_ACTION, 16'h0080, 1'b0);
      tally_and_finish();
   end
endmodule
